/* File: verilog/plc_low_cut.sv */
// Pressure output low-cut, transfer selection and static pressure ranging
//
// Summary of operation
// - Low-cut threshold limited to 0..20 % span.
// - Hysteresis of plus/minus ten percent of threshold.
// - Cut mode linear or zero, linear default.
// - Default threshold 10 %, 1 % for lin/sqrt.
// - Revisions before 2.02 use 10 % default.
// - Lin/sqrt display cut at square-root threshold.
// - Sqrt output, linear display: display uncut.
// - Reverse swap treats low port as high.
// - Static lower is 0 %, upper 100 %.
// - Capture sets static lower and upper together.
// - Static display defaults to absolute pressure.
// - Atmospheric reference defaults to 0.1013 MPa.
// - Output and display transfer chosen independently.
`timescale 1ns/1ps
`include "plc_cfg.svh"
module plc_low_cut #(
   parameter logic [15:0] FW_REV = `PLC_FW_REV_DEFAULT
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic sampleValid,
   input wire logic [15:0] highSide,
   input wire logic [15:0] lowSide,
   input wire logic staticValid,
   input wire logic [15:0] staticAbs,
   input wire logic cfgWrite,
   input wire logic [15:0] cfgLowCut,
   input wire logic cfgCutZero,
   input wire logic cfgOutSqrt,
   input wire logic cfgDispSqrt,
   input wire logic cfgSwapReverse,
   input wire logic cfgGauge,
   input wire logic [15:0] cfgAtmRef,
   input wire logic loadDefaults,
   input wire logic rangeWrite,
   input wire logic [15:0] static_range_lower,
   input wire logic [15:0] static_range_upper,
   input wire logic static_range_capture,
   output logic outValid,
   output logic [15:0] outPct,
   output logic [15:0] dispPct,
   output logic outCutActive,
   output logic dispCutActive,
   output logic [15:0] lowCutNow,
   output logic [15:0] staticValue,
   output logic staticPctValid,
   output logic [15:0] staticPct,
   output logic [15:0] spLowerNow,
   output logic [15:0] spUpperNow
);

   plc_pkg::plc_state_t q;
   plc_pkg::plc_state_t d;

   logic [16:0] diffHigh;
   logic [16:0] diffLow;
   logic [15:0] xIn;
   logic [15:0] sqrtX;
   logic [15:0] sqrtT;
   logic [16:0] cutLo;
   logic [16:0] cutHi;
   logic [16:0] sqLo;
   logic [16:0] sqHi;
   logic [15:0] reportNow;
   logic [15:0] spanNow;
   logic [16:0] divShift;
   logic [15:0] divQuoNext;

   function automatic logic [15:0] defaultCut(input logic outSq, input logic dispSq);
      if (!outSq && dispSq && (FW_REV >= `PLC_FW_REV_1PCT)) begin
         defaultCut = `PLC_LC_1PCT;
      end else begin
         defaultCut = `PLC_LC_10PCT;
      end
   endfunction : defaultCut

   // Inside the band the previous decision holds, which stops chatter
   function automatic logic nextCut(input logic cur, input logic [15:0] v, input logic [16:0] lo,
                                    input logic [16:0] hi);
      if ({1'b0, v} < lo) begin
         nextCut = 1'b1;
      end else if ({1'b0, v} > hi) begin
         nextCut = 1'b0;
      end else begin
         nextCut = cur;
      end
   endfunction : nextCut

   // A negative differential clamps to 0 % rather than wrapping
   assign diffHigh = {1'b0, highSide} - {1'b0, lowSide};
   assign diffLow = {1'b0, lowSide} - {1'b0, highSide};
   assign xIn = q.swapRev ? (diffLow[16] ? `PLC_PCT_ZERO : diffLow[15:0]) :
                            (diffHigh[16] ? `PLC_PCT_ZERO : diffHigh[15:0]);

   plc_isqrt u_sqrt_in (
      .radicand({xIn, 16'h0000}),
      .root(sqrtX)
   );

   plc_isqrt u_sqrt_cut (
      .radicand({q.lowCut, 16'h0000}),
      .root(sqrtT)
   );

   assign cutLo = {1'b0, q.lowCut} - {1'b0, q.lowCut / `PLC_HYST_DIV};
   assign cutHi = {1'b0, q.lowCut} + {1'b0, q.lowCut / `PLC_HYST_DIV};
   assign sqLo = {1'b0, sqrtT} - {1'b0, sqrtT / `PLC_HYST_DIV};
   assign sqHi = {1'b0, sqrtT} + {1'b0, sqrtT / `PLC_HYST_DIV};

   assign reportNow = !q.gauge ? staticAbs :
                      (staticAbs > q.atmRef) ? staticAbs - q.atmRef : `PLC_PCT_ZERO;
   assign spanNow = q.spUpper - q.spLower;
   assign divShift = {q.divRem, 1'b0};
   assign divQuoNext = {q.divQuo[14:0], (divShift >= {1'b0, q.divDen})};

   always_comb begin
      d = q;
      d.outValid = 1'b0;
      d.pctValid = 1'b0;
      if (cfgWrite) begin
         d.lowCut = (cfgLowCut > `PLC_LC_MAX) ? `PLC_LC_MAX : cfgLowCut;
         d.cutZero = cfgCutZero;
         d.outSqrt = cfgOutSqrt;
         d.dispSqrt = cfgDispSqrt;
         d.swapRev = cfgSwapReverse;
         d.gauge = cfgGauge;
         d.atmRef = cfgAtmRef;
      end
      // Defaults follow the transfer modes as they stand after this cycle's write
      if (loadDefaults) begin
         d.lowCut = defaultCut(d.outSqrt, d.dispSqrt);
      end
      if (sampleValid) begin
         d.outValid = 1'b1;
         d.outCut = nextCut(q.outCut, xIn, cutLo, cutHi);
         if (d.outCut) begin
            d.outPct = q.cutZero ? `PLC_PCT_ZERO : xIn;
         end else begin
            d.outPct = q.outSqrt ? sqrtX : xIn;
         end
         if (q.outSqrt && !q.dispSqrt) begin
            d.dispCut = 1'b0;
         end else if (!q.outSqrt && q.dispSqrt) begin
            d.dispCut = nextCut(q.dispCut, sqrtX, sqLo, sqHi);
         end else begin
            d.dispCut = nextCut(q.dispCut, xIn, cutLo, cutHi);
         end
         if (d.dispCut) begin
            d.dispPct = q.cutZero ? `PLC_PCT_ZERO : xIn;
         end else begin
            d.dispPct = q.dispSqrt ? sqrtX : xIn;
         end
      end
      if (rangeWrite) begin
         d.spLower = static_range_lower;
         d.spUpper = static_range_upper;
      end else if (static_range_capture) begin
         // Span is kept, so both ends move in the same cycle
         d.spLower = q.staticValue;
         d.spUpper = q.staticValue + spanNow;
      end
      if (staticValid) begin
         d.staticValue = reportNow;
      end
      case (q.divState)
         plc_pkg::PLC_DIV_IDLE: begin
            // Samples arriving while a division runs update the value only
            if (staticValid) begin
               if (q.spUpper <= q.spLower || reportNow <= q.spLower) begin
                  d.staticPct = `PLC_PCT_ZERO;
                  d.pctValid = 1'b1;
               end else if (reportNow >= q.spUpper) begin
                  d.staticPct = `PLC_PCT_FULL;
                  d.pctValid = 1'b1;
               end else begin
                  d.divRem = reportNow - q.spLower;
                  d.divDen = spanNow;
                  d.divQuo = `PLC_PCT_ZERO;
                  d.divCnt = `PLC_DIV_STEPS;
                  d.divState = plc_pkg::PLC_DIV_RUN;
               end
            end
         end
         plc_pkg::PLC_DIV_RUN: begin
            if (divShift >= {1'b0, q.divDen}) begin
               d.divRem = 16'(divShift - {1'b0, q.divDen});
            end else begin
               d.divRem = divShift[15:0];
            end
            d.divQuo = divQuoNext;
            d.divCnt = q.divCnt - 5'h01;
            if (q.divCnt == 5'h01) begin
               d.staticPct = divQuoNext;
               d.pctValid = 1'b1;
               d.divState = plc_pkg::PLC_DIV_IDLE;
            end
         end
         default: begin
            d.divState = plc_pkg::PLC_DIV_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         q <= '0;
         q.lowCut <= `PLC_LC_10PCT;
         q.cutZero <= 1'b0;
         q.gauge <= 1'b0;
         q.atmRef <= `PLC_ATM_DEFAULT;
         q.spLower <= `PLC_SP_LOWER_RST;
         q.spUpper <= `PLC_SP_UPPER_RST;
         q.divState <= plc_pkg::PLC_DIV_IDLE;
      end else begin
         q <= d;
      end
   end

   assign outValid = q.outValid;
   assign outPct = q.outPct;
   assign dispPct = q.dispPct;
   assign outCutActive = q.outCut;
   assign dispCutActive = q.dispCut;
   assign lowCutNow = q.lowCut;
   assign staticValue = q.staticValue;
   assign staticPctValid = q.pctValid;
   assign staticPct = q.staticPct;
   assign spLowerNow = q.spLower;
   assign spUpperNow = q.spUpper;

   lowcut_limit_a: assert property (@(posedge clk) disable iff (!rstn)
      cfgWrite && !loadDefaults |=> lowCutNow <= `PLC_LC_MAX && lowCutNow <= $past(cfgLowCut))
      else $error("low-cut threshold above limit");

   cut_enter_a: assert property (@(posedge clk) disable iff (!rstn)
      sampleValid && ({1'b0, xIn} < cutLo) |=> outCutActive && outValid)
      else $error("cut not entered below band");

   cut_release_a: assert property (@(posedge clk) disable iff (!rstn)
      sampleValid && ({1'b0, xIn} > cutHi) |=> !outCutActive)
      else $error("cut not released above band");

   cut_hold_a: assert property (@(posedge clk) disable iff (!rstn)
      sampleValid && ({1'b0, xIn} >= cutLo) && ({1'b0, xIn} <= cutHi) |=> $stable(outCutActive))
      else $error("cut changed inside hysteresis band");

   zero_force_a: assert property (@(posedge clk) disable iff (!rstn)
      sampleValid && q.cutZero && !cfgWrite ##1 outCutActive |-> outPct == `PLC_PCT_ZERO)
      else $error("zero mode output not forced to zero");

   linear_pass_a: assert property (@(posedge clk) disable iff (!rstn)
      sampleValid && !q.cutZero && !q.outSqrt |=> outPct == $past(xIn))
      else $error("linear output differs from input");

   default_cut_a: assert property (@(posedge clk) disable iff (!rstn)
      loadDefaults && !cfgWrite && !(!q.outSqrt && q.dispSqrt) |=> lowCutNow == `PLC_LC_10PCT)
      else $error("default threshold not ten percent");

   default_rev_a: assert property (@(posedge clk) disable iff (!rstn)
      loadDefaults && !cfgWrite && !q.outSqrt && q.dispSqrt |=>
      lowCutNow == ((FW_REV >= `PLC_FW_REV_1PCT) ? `PLC_LC_1PCT : `PLC_LC_10PCT))
      else $error("revision dependent default wrong");

   disp_sqrtcut_a: assert property (@(posedge clk) disable iff (!rstn)
      sampleValid && !q.outSqrt && q.dispSqrt && ({1'b0, sqrtX} < sqLo) |=> dispCutActive)
      else $error("display cut not at root of threshold");

   disp_nocut_a: assert property (@(posedge clk) disable iff (!rstn)
      sampleValid && q.outSqrt && !q.dispSqrt |=> !dispCutActive)
      else $error("display cut applied with root output");

   swap_dir_a: assert property (@(posedge clk) disable iff (!rstn)
      q.swapRev && lowSide > highSide |-> xIn == lowSide - highSide)
      else $error("reverse swap not using low side");

   range_pct_a: assert property (@(posedge clk) disable iff (!rstn)
      staticValid && q.divState == plc_pkg::PLC_DIV_IDLE && reportNow <= q.spLower |=>
      staticPctValid && staticPct == `PLC_PCT_ZERO)
      else $error("static percent not zero at lower range");

   div_time_a: assert property (@(posedge clk) disable iff (!rstn)
      $rose(q.divState == plc_pkg::PLC_DIV_RUN) |-> ##16 staticPctValid)
      else $error("static percent late");

   capture_a: assert property (@(posedge clk) disable iff (!rstn)
      static_range_capture && !rangeWrite |=>
      spLowerNow == $past(staticValue) && (spUpperNow - spLowerNow) == $past(spanNow))
      else $error("capture did not move both ends");

   gauge_a: assert property (@(posedge clk) disable iff (!rstn)
      staticValid && q.gauge && staticAbs > q.atmRef |=> staticValue == $past(staticAbs) - $past(q.atmRef))
      else $error("gauge value not absolute minus reference");

endmodule : plc_low_cut

/* File: verilog/plc_cfg.svh */
// Constants of the pressure output low-cut block
`ifndef PLC_CFG_SVH
`define PLC_CFG_SVH

// Percent scale: 16'h0000 is 0 %, 16'hFFFF is 100 % of span
`define PLC_LC_MAX 16'h3333
`define PLC_LC_10PCT 16'h199A
`define PLC_LC_1PCT 16'h028F
`define PLC_PCT_FULL 16'hFFFF
`define PLC_PCT_ZERO 16'h0000

// Hysteresis band spans the cut point divided by this on either side of it
`define PLC_HYST_DIV 16'h000A

// Firmware revision from which the 1 % default applies (2.02)
`define PLC_FW_REV_1PCT 16'h0202
`define PLC_FW_REV_DEFAULT 16'h0202

// Static pressure in units of 0.0001 MPa
`define PLC_ATM_DEFAULT 16'h03F5
`define PLC_SP_LOWER_RST 16'h0000
`define PLC_SP_UPPER_RST 16'hFFFF

// Steps of the restoring divider for the static percent
`define PLC_DIV_STEPS 5'h10

`endif

/* File: verilog/plc_pkg.sv */
// Types of the pressure output low-cut block
package plc_pkg;

   typedef enum logic {
      PLC_DIV_IDLE,
      PLC_DIV_RUN
   } plc_div_state_t;

   typedef struct packed {
      logic [15:0] lowCut;
      logic cutZero;
      logic outSqrt;
      logic dispSqrt;
      logic swapRev;
      logic gauge;
      logic [15:0] atmRef;
      logic [15:0] spLower;
      logic [15:0] spUpper;
      logic outCut;
      logic dispCut;
      logic outValid;
      logic [15:0] outPct;
      logic [15:0] dispPct;
      logic [15:0] staticValue;
      plc_div_state_t divState;
      logic [4:0] divCnt;
      logic [15:0] divRem;
      logic [15:0] divQuo;
      logic [15:0] divDen;
      logic pctValid;
      logic [15:0] staticPct;
   } plc_state_t;

endpackage : plc_pkg

/* File: verilog/plc_isqrt.sv */
// Combinational integer square root, one stage per result bit
`timescale 1ns/1ps
module plc_isqrt (
   input wire logic [31:0] radicand,
   output logic [15:0] root
);

   logic [15:0] stage [0:16];

   assign stage[16] = 16'h0000;

   genvar i;
   generate
      for (i = 0; i < 16; i++) begin : g_bit
         logic [15:0] cand;
         logic [31:0] square;
         assign cand = stage[i + 1] | (16'h0001 << i);
         assign square = {16'h0000, cand} * {16'h0000, cand};
         assign stage[i] = (square <= radicand) ? cand : stage[i + 1];
      end
   endgenerate

   assign root = stage[0];

endmodule : plc_isqrt

/* File: dv/plc_sensor_src.sv */
// Behavioural pressure and static sensor sample source
`timescale 1ns/1ps
module plc_sensor_src (
   input wire logic clk,
   output logic sampleValid,
   output logic [15:0] highSide,
   output logic [15:0] lowSide,
   output logic staticValid,
   output logic [15:0] staticAbs
);
   initial begin
      sampleValid = 1'b0;
      highSide = 16'h0000;
      lowSide = 16'h0000;
      staticValid = 1'b0;
      staticAbs = 16'h0000;
   end

   // One strobed sample; afterwards data lines flip so stale data never looks valid
   task automatic send(input logic isStatic, input logic [15:0] a, input logic [15:0] b);
      @(posedge clk);
      sampleValid <= !isStatic;
      staticValid <= isStatic;
      if (isStatic) begin
         staticAbs <= a;
      end else begin
         highSide <= a;
         lowSide <= b;
      end
      @(posedge clk);
      sampleValid <= 1'b0;
      staticValid <= 1'b0;
      highSide <= ~highSide;
      lowSide <= ~lowSide;
      staticAbs <= ~staticAbs;
   endtask : send
endmodule : plc_sensor_src

/* File: dv/tb_plc_low_cut.sv */
// Self-checking testbench of the pressure output low-cut block
`timescale 1ns/1ps
module tb_plc_low_cut;
   logic clk, rstn, cfgWrite, cfgCutZero, cfgOutSqrt, cfgDispSqrt, cfgSwapReverse, cfgGauge;
   logic loadDefaults, rangeWrite, static_range_capture;
   logic [15:0] cfgLowCut, cfgAtmRef, static_range_lower, static_range_upper;
   logic sampleValid, staticValid, outValid, outCutActive, dispCutActive, staticPctValid;
   logic [15:0] highSide, lowSide, staticAbs, outPct, dispPct, lowCutNow, staticValue;
   logic [15:0] staticPct, spLowerNow, spUpperNow, lowCutOld;
   int badCount = 0;
   int checkCount = 0;
   int cycles = 0;
   // First sample clears the cut left by earlier tests, so the band starts uncut
   logic [15:0] hx [5] = '{16'h119A, 16'h0E67, 16'h0E66, 16'h1199, 16'h119A};
   logic [15:0] hp [5] = '{16'h119A, 16'h0E67, 16'h0000, 16'h0000, 16'h119A};
   logic hc [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};

   plc_sensor_src src (.clk(clk), .sampleValid(sampleValid), .highSide(highSide), .lowSide(lowSide),
      .staticValid(staticValid), .staticAbs(staticAbs));

   plc_low_cut dut (.clk, .rstn, .sampleValid, .highSide, .lowSide, .staticValid, .staticAbs,
      .cfgWrite, .cfgLowCut, .cfgCutZero, .cfgOutSqrt, .cfgDispSqrt, .cfgSwapReverse, .cfgGauge,
      .cfgAtmRef, .loadDefaults, .rangeWrite, .static_range_lower, .static_range_upper,
      .static_range_capture, .outValid, .outPct, .dispPct, .outCutActive, .dispCutActive,
      .lowCutNow, .staticValue, .staticPctValid, .staticPct, .spLowerNow, .spUpperNow);

   // Older revision keeps the 10 % default in every mode
   plc_low_cut #(.FW_REV(16'h0201)) dutOld (.clk, .rstn, .sampleValid, .highSide, .lowSide,
      .staticValid, .staticAbs, .cfgWrite, .cfgLowCut, .cfgCutZero, .cfgOutSqrt, .cfgDispSqrt,
      .cfgSwapReverse, .cfgGauge, .cfgAtmRef, .loadDefaults, .rangeWrite, .static_range_lower,
      .static_range_upper, .static_range_capture, .outValid(), .outPct(), .dispPct(),
      .outCutActive(), .dispCutActive(), .lowCutNow(lowCutOld), .staticValue(),
      .staticPctValid(), .staticPct(), .spLowerNow(), .spUpperNow());

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task automatic completeRun();
      $display("checks %0d mismatches %0d", checkCount, badCount);
      if (badCount == 0 && checkCount > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : completeRun

   always @(posedge clk) begin
      cycles++;
      if (cycles == 6000) begin
         badCount++;
         completeRun();
      end
   end

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checkCount++;
      if (seen !== exp) begin
         badCount++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // Mode bits: zero cut, output sqrt, display sqrt, reverse, gauge
   task automatic cfg(input logic [15:0] t, input logic [4:0] m, input logic ld);
      @(posedge clk);
      cfgWrite <= 1'b1;
      loadDefaults <= ld;
      cfgLowCut <= t;
      {cfgCutZero, cfgOutSqrt, cfgDispSqrt, cfgSwapReverse, cfgGauge} <= m;
      @(posedge clk);
      cfgWrite <= 1'b0;
      loadDefaults <= 1'b0;
      #1;
   endtask : cfg

   task automatic rng(input logic wr, input logic cap, input logic [15:0] lo, input logic [15:0] up);
      @(posedge clk);
      rangeWrite <= wr;
      static_range_capture <= cap;
      static_range_lower <= lo;
      static_range_upper <= up;
      @(posedge clk);
      rangeWrite <= 1'b0;
      static_range_capture <= 1'b0;
      #1;
   endtask : rng

   task automatic smp(input logic [15:0] a, input logic [15:0] b);
      src.send(1'b0, a, b);
      #1;
      check("outValid", {15'h0000, outValid}, 16'h0001);
   endtask : smp

   task automatic stat(input logic [15:0] v);
      int n;
      src.send(1'b1, v, 16'h0000);
      #1;
      n = 0;
      while (staticPctValid !== 1'b1 && n < 40) begin
         @(posedge clk);
         #1;
         n++;
      end
      check("staticPctValid", {15'h0000, staticPctValid}, 16'h0001);
   endtask : stat

   initial begin
      rstn = 1'b0;
      {cfgWrite, loadDefaults, rangeWrite, static_range_capture} = 4'h0;
      {cfgCutZero, cfgOutSqrt, cfgDispSqrt, cfgSwapReverse, cfgGauge} = 5'h00;
      cfgLowCut = 16'h0000;
      cfgAtmRef = 16'h03F5;
      static_range_lower = 16'h0000;
      static_range_upper = 16'hFFFF;
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      #1;
      check("lowCutNow", lowCutNow, 16'h199A);
      check("spLowerNow", spLowerNow, 16'h0000);
      check("spUpperNow", spUpperNow, 16'hFFFF);
      smp(16'h0100, 16'h0000);
      check("outCutActive", {15'h0000, outCutActive}, 16'h0001);
      check("outPct", outPct, 16'h0100);
      stat(16'h2710);
      check("staticValue", staticValue, 16'h2710);
      check("staticPct", staticPct, 16'h2710);
      for (int i = 0; i < 8; i++) begin
         cfg(16'h3000, {1'b0, i[1:0], 2'b00}, !i[2]);
         // Second pass loads the defaults alone, with the modes already stored
         if (i[2]) begin
            @(posedge clk);
            loadDefaults <= 1'b1;
            @(posedge clk);
            loadDefaults <= 1'b0;
            #1;
         end
         check("lowCutNow", lowCutNow, (i[1:0] == 2'b01) ? 16'h028F : 16'h199A);
         check("lowCutOld", lowCutOld, 16'h199A);
      end
      cfg(16'h3334, 5'h00, 1'b0);
      check("lowCutNow", lowCutNow, 16'h3333);
      cfg(16'h0000, 5'h00, 1'b0);
      check("lowCutNow", lowCutNow, 16'h0000);
      cfg(16'h1000, 5'h10, 1'b0);
      for (int i = 0; i < 5; i++) begin
         smp(hx[i], 16'h0000);
         check("outPct", outPct, hp[i]);
         check("outCutActive", {15'h0000, outCutActive}, {15'h0000, hc[i]});
      end
      cfg(16'h1000, 5'h00, 1'b0);
      smp(16'h0E66, 16'h0000);
      check("outPct", outPct, 16'h0E66);
      cfg(16'h1000, 5'h02, 1'b0);
      smp(16'h0000, 16'h2000);
      check("outPct", outPct, 16'h2000);
      cfg(16'h1000, 5'h00, 1'b0);
      smp(16'h0000, 16'h2000);
      check("outPct", outPct, 16'h0000);
      cfg(16'h1000, 5'h18, 1'b0);
      smp(16'h0100, 16'h0000);
      check("outPct", outPct, 16'h0000);
      check("dispCutActive", {15'h0000, dispCutActive}, 16'h0000);
      check("dispPct", dispPct, 16'h0100);
      // 25 % of span through the root transfer gives 50 %
      smp(16'h4000, 16'h0000);
      check("outPct", outPct, 16'h8000);
      check("dispPct", dispPct, 16'h4000);
      // Display band sits on the root of the threshold: 1.15 T clears output only
      cfg(16'h0400, 5'h14, 1'b0);
      smp(16'h0000, 16'h0000);
      check("dispCutActive", {15'h0000, dispCutActive}, 16'h0001);
      smp(16'h049A, 16'h0000);
      check("outCutActive", {15'h0000, outCutActive}, 16'h0000);
      check("dispCutActive", {15'h0000, dispCutActive}, 16'h0001);
      smp(16'h0500, 16'h0000);
      check("dispCutActive", {15'h0000, dispCutActive}, 16'h0000);
      check("dispPct", dispPct, 16'h23C6);
      cfg(16'h1000, 5'h01, 1'b0);
      rng(1'b1, 1'b0, 16'h0000, 16'h2000);
      stat(16'h13F5);
      check("staticValue", staticValue, 16'h1000);
      check("staticPct", staticPct, 16'h8000);
      rng(1'b0, 1'b1, 16'h0000, 16'h0000);
      check("spLowerNow", spLowerNow, 16'h1000);
      check("spUpperNow", spUpperNow, 16'h3000);
      stat(16'h13F5);
      check("staticPct", staticPct, 16'h0000);
      completeRun();
   end
endmodule : tb_plc_low_cut
